// File: logic/mafr_defines.svh
`ifndef MAFR_DEFINES_SVH
`define MAFR_DEFINES_SVH

// ----------------------------------------
// register byte offsets on the bus
// ----------------------------------------
`define MAFR_OFS_AUX_CTRL  8'h00
`define MAFR_OFS_TTB       8'h04
`define MAFR_OFS_FAULT     8'h08
`define MAFR_OFS_FAR       8'h0c
`define MAFR_OFS_IRQ_STAT  8'h10
`define MAFR_OFS_IRQ_MASK  8'h14

// ----------------------------------------
// auxiliary control field positions
// ----------------------------------------
`define MAFR_AUX_NOCOAL_BIT  0
`define MAFR_AUX_PATTR_BIT   1
`define MAFR_AUX_POL_LO      4
`define MAFR_AUX_POL_HI      5

// ----------------------------------------
// translation table base and fault cause layout
// ----------------------------------------
`define MAFR_TTB_LO          14
`define MAFR_FC_STAT_HI      3
`define MAFR_FC_DOM_LO       4
`define MAFR_FC_DOM_HI       7
`define MAFR_FC_DEBUG_BIT    9
`define MAFR_FC_EXT_BIT      10

// ----------------------------------------
// interrupt event bits and reset values
// ----------------------------------------
`define MAFR_EV_PREFETCH     0
`define MAFR_EV_DATA         1
`define MAFR_EV_DEBUG        2
`define MAFR_RST_AUX         2'h0
`define MAFR_RST_WORD        32'h0000_0000

`endif

// File: logic/mafr_pkg.sv
package mafr_pkg;

	// mini-data cache policy encodings
	typedef enum logic [1:0]
	{
		MAFR_WB_RA   = 2'b00,
		MAFR_WB_RWA  = 2'b01,
		MAFR_WT_RA   = 2'b10,
		MAFR_UNPRED  = 2'b11
	} mafr_policy_t;

	// bus slave state
	typedef struct packed
	{
		logic ack;
	} mafr_bus_state_t;

	// register bank state
	typedef struct packed
	{
		mafr_policy_t  policy;       // mini cache policy
		logic          page_attr;    // page table attribute bit
		logic          no_coalesce;  // global coalescing disable
		logic [17:0]   ttb;          // table base, bits 31:14
		logic [3:0]    fc_status;    // fault status code
		logic [3:0]    fc_domain;    // fault domain
		logic          fc_debug;     // debug event abort
		logic          fc_ext;       // status extension
		logic [31:0]   far;          // fault address
		logic [2:0]    irq_stat;     // sticky events
		logic [2:0]    irq_mask;     // event enables
		logic [31:0]   rdata;        // read data holding
	} mafr_regs_t;

endpackage

// File: logic/mafr_bus_slave.sv
// classic wishbone handshake: one ack per request, one cycle after it
module mafr_bus_slave
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic cyc_i,
	input  wire logic stb_i,
	input  wire logic we_i,
	output logic      ack_o,
	output logic      rd_take_o,
	output logic      wr_commit_o
);
	import mafr_pkg::*;

	mafr_bus_state_t st_reg;   // registered state
	mafr_bus_state_t st_next;  // next state

	// ----------------------------------------
	// handshake
	// ----------------------------------------
	// the ack drops after one cycle so a held request is answered every other cycle
	always_comb
	begin
		st_next     = st_reg;
		st_next.ack = cyc_i && stb_i && !st_reg.ack;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign ack_o       = st_reg.ack;
	// read data is captured as the request is seen
	assign rd_take_o   = cyc_i && stb_i && !st_reg.ack && !we_i;
	// writes land on the edge at which the master samples ack
	assign wr_commit_o = cyc_i && stb_i && st_reg.ack && we_i;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

endmodule

// File: logic/mafr_store_policy.sv
// store path decisions for the write buffer and mini-data cache
module mafr_store_policy
(
	input  wire logic       no_coalesce_i,
	input  wire logic [1:0] policy_i,
	input  wire logic       store_valid_i,
	input  wire logic       store_mini_i,
	input  wire logic       page_coalesce_i,
	output logic            store_buffer_o,
	output logic            store_merge_o,
	output logic            write_alloc_o,
	output logic            write_through_o
);
	import mafr_pkg::*;

	// ----------------------------------------
	// buffering and merging
	// ----------------------------------------
	always_comb
	begin
		// mini-cacheable stores always go through the write buffer
		store_buffer_o = store_valid_i && (store_mini_i || page_coalesce_i); // RULE2
		// global disable overrides every page attribute
		store_merge_o  = store_buffer_o && !no_coalesce_i &&
			(store_mini_i || page_coalesce_i); // RULE3 RULE4
	end

	// ----------------------------------------
	// mini cache policy decode
	// ----------------------------------------
	// the unpredictable code acts as write-back, read allocate here
	always_comb
	begin
		case (mafr_policy_t'(policy_i)) // RULE1
			MAFR_WB_RWA:
			begin
				write_alloc_o   = 1'b1;
				write_through_o = 1'b0;
			end
			MAFR_WT_RA:
			begin
				write_alloc_o   = 1'b0;
				write_through_o = 1'b1;
			end
			default:
			begin
				write_alloc_o   = 1'b0;
				write_through_o = 1'b0;
			end
		endcase
	end

endmodule

// File: logic/mafr_regs.sv
// What this block does
// RULE1: policy bits 5:4 pick mini cache policy
// RULE2: mini-cacheable stores always enter write buffer
// RULE3: bit 0 set stops all store merging
// RULE4: bit 0 clear lets page attributes decide
// RULE5: software writes zero to page attribute bit
// RULE6: reset clears every auxiliary control bit
// RULE7: table base bits 31:14 drive page walks
// RULE8: abort entry loads the fault cause register
// RULE9: bit 10 extends the fault status code
// RULE10: bit 9 flags aborts from debug events
// RULE11: debug aborts leave domain, extension undefined
// RULE12: each abort overwrites fault fields directly
// RULE13: data aborts capture full virtual address
// RULE14: software sets policy before mini caching
// RULE15: reserved bits ignore writes, read zero
`include "mafr_defines.svh"

module mafr_regs
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	output logic             irq_o,
	// abort reports from the core
	input  wire logic        abort_i,
	input  wire logic        abort_is_data_i,
	input  wire logic [3:0]  abort_status_i,
	input  wire logic        abort_ext_i,
	input  wire logic [3:0]  abort_domain_i,
	input  wire logic        abort_debug_i,
	input  wire logic [31:0] modified_virtual_address_i,
	// write buffer store path
	input  wire logic        store_valid_i,
	input  wire logic        store_mini_i,
	input  wire logic        page_coalesce_i,
	output logic             store_buffer_o,
	output logic             store_merge_o,
	// controls toward mmu and mini cache
	output logic [1:0]       mini_cache_policy_o,
	output logic             mini_write_alloc_o,
	output logic             mini_write_through_o,
	output logic [31:0]      table_base_o
);
	import mafr_pkg::*;

	mafr_regs_t  r_reg;       // all bank state
	mafr_regs_t  r_next;      // its next value
	logic        rd_take;     // read captured this cycle
	logic        wr_commit;   // write lands this cycle
	logic [2:0]  events;      // abort events this cycle
	logic [2:0]  w1c;         // status bits cleared by software
	logic [31:0] aux_word;    // assembled control word
	logic [31:0] ttb_word;    // assembled table base word
	logic [31:0] fc_word;     // assembled fault cause word
	logic [31:0] wv;          // write value after byte lanes

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// byte lane merge: only selected lanes take new data
	function automatic logic [31:0] lane_merge
	(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction

	// address match for a write that is landing
	function automatic logic wr_hit
	(
		input logic       commit,
		input logic [7:0] adr,
		input logic [7:0] ofs
	);
		return commit && (adr == ofs);
	endfunction

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	mafr_bus_slave u_bus
	(
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.cyc_i       (cyc_i),
		.stb_i       (stb_i),
		.we_i        (we_i),
		.ack_o       (ack_o),
		.rd_take_o   (rd_take),
		.wr_commit_o (wr_commit)
	);

	// ----------------------------------------
	// store path
	// ----------------------------------------
	mafr_store_policy u_store
	(
		.no_coalesce_i   (r_reg.no_coalesce),
		.policy_i        (r_reg.policy),
		.store_valid_i   (store_valid_i),
		.store_mini_i    (store_mini_i),
		.page_coalesce_i (page_coalesce_i),
		.store_buffer_o  (store_buffer_o),
		.store_merge_o   (store_merge_o),
		.write_alloc_o   (mini_write_alloc_o),
		.write_through_o (mini_write_through_o)
	);

	// ----------------------------------------
	// register words as software sees them
	// ----------------------------------------
	// reserved bits are held nowhere, so they read zero
	always_comb
	begin
		aux_word = `MAFR_RST_WORD; // RULE15
		aux_word[`MAFR_AUX_POL_HI:`MAFR_AUX_POL_LO] = r_reg.policy;
		aux_word[`MAFR_AUX_PATTR_BIT]  = r_reg.page_attr;
		aux_word[`MAFR_AUX_NOCOAL_BIT] = r_reg.no_coalesce;
		ttb_word = {r_reg.ttb, 14'h0000}; // RULE7 RULE15
		fc_word  = `MAFR_RST_WORD;
		fc_word[`MAFR_FC_STAT_HI:0] = r_reg.fc_status;
		fc_word[`MAFR_FC_DOM_HI:`MAFR_FC_DOM_LO] = r_reg.fc_domain;
		fc_word[`MAFR_FC_DEBUG_BIT] = r_reg.fc_debug;
		fc_word[`MAFR_FC_EXT_BIT]   = r_reg.fc_ext;
	end

	// ----------------------------------------
	// events and clears
	// ----------------------------------------
	always_comb
	begin
		events = 3'h0;
		events[`MAFR_EV_PREFETCH] = abort_i && !abort_is_data_i;
		events[`MAFR_EV_DATA]     = abort_i && abort_is_data_i;
		events[`MAFR_EV_DEBUG]    = abort_i && abort_debug_i;
		// clear only through the low byte lane
		w1c = (wr_hit(wr_commit, adr_i, `MAFR_OFS_IRQ_STAT) && sel_i[0]) ?
			dat_i[2:0] : 3'h0;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		r_next = r_reg;
		wv     = dat_i;

		// software writes, reserved bits dropped
		if (wr_hit(wr_commit, adr_i, `MAFR_OFS_AUX_CTRL))
		begin
			wv = lane_merge(aux_word, dat_i, sel_i);
			r_next.policy      = mafr_policy_t'(wv[`MAFR_AUX_POL_HI:`MAFR_AUX_POL_LO]); // RULE1
			// stored as written; the bit drives nothing
			r_next.page_attr   = wv[`MAFR_AUX_PATTR_BIT];
			r_next.no_coalesce = wv[`MAFR_AUX_NOCOAL_BIT]; // RULE3
		end
		if (wr_hit(wr_commit, adr_i, `MAFR_OFS_TTB))
		begin
			wv = lane_merge(ttb_word, dat_i, sel_i);
			r_next.ttb = wv[31:`MAFR_TTB_LO]; // RULE7
		end
		if (wr_hit(wr_commit, adr_i, `MAFR_OFS_FAULT))
		begin
			wv = lane_merge(fc_word, dat_i, sel_i);
			r_next.fc_status = wv[`MAFR_FC_STAT_HI:0];
			r_next.fc_domain = wv[`MAFR_FC_DOM_HI:`MAFR_FC_DOM_LO];
			r_next.fc_debug  = wv[`MAFR_FC_DEBUG_BIT];
			r_next.fc_ext    = wv[`MAFR_FC_EXT_BIT];
		end
		if (wr_hit(wr_commit, adr_i, `MAFR_OFS_FAR))
			r_next.far = lane_merge(r_reg.far, dat_i, sel_i); // RULE13
		if (wr_hit(wr_commit, adr_i, `MAFR_OFS_IRQ_MASK) && sel_i[0])
			r_next.irq_mask = dat_i[2:0];

		// an abort in the same cycle as a write wins for the fault fields, and a data abort for the address too: it is newer
		if (abort_i)
		begin
			r_next.fc_status = abort_status_i; // RULE8 RULE12
			r_next.fc_debug  = abort_debug_i; // RULE10
			if (abort_debug_i)
			begin
				// fields carry no meaning, held at zero
				r_next.fc_domain = 4'h0; // RULE11
				r_next.fc_ext    = 1'b0; // RULE11
			end
			else
			begin
				r_next.fc_domain = abort_domain_i;
				r_next.fc_ext    = abort_ext_i; // RULE9
			end
			// only data accesses have an address to record
			if (abort_is_data_i)
				r_next.far = modified_virtual_address_i; // RULE13
		end

		// sticky status: a new event beats a clear
		r_next.irq_stat = (r_reg.irq_stat & ~w1c) | events;

		// read capture, unmapped offsets answer zero
		if (rd_take)
		begin
			case (adr_i)
				`MAFR_OFS_AUX_CTRL: r_next.rdata = aux_word;
				`MAFR_OFS_TTB:      r_next.rdata = ttb_word;
				`MAFR_OFS_FAULT:    r_next.rdata = fc_word;
				`MAFR_OFS_FAR:      r_next.rdata = r_reg.far;
				`MAFR_OFS_IRQ_STAT: r_next.rdata = {29'h0, r_reg.irq_stat};
				`MAFR_OFS_IRQ_MASK: r_next.rdata = {29'h0, r_reg.irq_mask};
				default:            r_next.rdata = `MAFR_RST_WORD;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// table base and fault fields also reset, for a clean simulation
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r_reg <= '0;
			r_reg.policy <= mafr_policy_t'(`MAFR_RST_AUX); // RULE6
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign dat_o               = r_reg.rdata;
	assign irq_o               = |(r_reg.irq_stat & r_reg.irq_mask);
	assign mini_cache_policy_o = r_reg.policy;
	assign table_base_o        = ttb_word;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	far_capture_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
		abort_i && abort_is_data_i |=> r_reg.far == $past(modified_virtual_address_i))
		else $error("fault address not captured on data abort");

	fault_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
		abort_i |=> fc_word[3:0] == $past(abort_status_i))
		else $error("fault status not loaded on abort");

	debug_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
		abort_i |=> fc_word[`MAFR_FC_DEBUG_BIT] == $past(abort_debug_i))
		else $error("debug flag does not follow abort");

	debug_fields_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
		abort_i && abort_debug_i |=>
		{fc_word[`MAFR_FC_EXT_BIT], fc_word[`MAFR_FC_DOM_HI:`MAFR_FC_DOM_LO]} == 5'h00)
		else $error("domain or extension set on debug abort");

	ext_bit_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
		abort_i && !abort_debug_i |=> fc_word[`MAFR_FC_EXT_BIT] == $past(abort_ext_i))
		else $error("status extension bit lost");

	aux_reset_a: assert property (@(posedge clk_i) // RULE6
		$fell(rst_i) |-> aux_word == `MAFR_RST_WORD && mini_cache_policy_o == 2'h0)
		else $error("control register not cleared by reset");

	ttb_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
		rd_take && adr_i == `MAFR_OFS_TTB |=> ack_o && dat_o[13:0] == 14'h0000)
		else $error("table base low bits not zero");

	merge_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		r_reg.no_coalesce |-> !store_merge_o)
		else $error("store merged while coalescing disabled");

	mini_buffer_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
		store_valid_i && store_mini_i |-> store_buffer_o)
		else $error("mini cacheable store not buffered");

	sticky_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		abort_i && abort_is_data_i |=> r_reg.irq_stat[`MAFR_EV_DATA] ##1
		r_reg.irq_stat[`MAFR_EV_DATA] || $past(w1c[`MAFR_EV_DATA]))
		else $error("data abort event not held");

endmodule

// File: tb/mafr_core_model.sv
// core side model: abort reports and store requests toward the bank
module mafr_core_model
(
	input  wire logic   clk_i,
	output logic        abort_o,
	output logic        abort_is_data_o,
	output logic [3:0]  abort_status_o,
	output logic        abort_ext_o,
	output logic [3:0]  abort_domain_o,
	output logic        abort_debug_o,
	output logic [31:0] address_o,
	output logic        store_valid_o,
	output logic        store_mini_o,
	output logic        page_coalesce_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	initial
	begin
		{abort_o, abort_is_data_o, abort_status_o, abort_ext_o} = '0;
		{abort_domain_o, abort_debug_o, address_o} = '0;
		{store_valid_o, store_mini_o, page_coalesce_o} = '0;
	end

	// one-cycle abort handler entry; called just after a rising edge
	task automatic abort_evt(input logic d, input logic [3:0] st, input logic e,
		input logic [3:0] dm, input logic g, input logic [31:0] a);
		abort_o <= 1'b1;
		abort_is_data_o <= d;
		{abort_status_o, abort_ext_o, abort_domain_o, abort_debug_o} <= {st, e, dm, g};
		address_o <= a;
		@(posedge clk_i);
		abort_o <= 1'b0;
		// fields no longer valid: scramble so stale values cannot pass
		abort_is_data_o <= ~d;
		{abort_status_o, abort_ext_o, abort_domain_o, abort_debug_o} <= ~{st, e, dm, g};
		address_o <= ~a;
	endtask

	// present one store for a cycle; returns at the falling edge inside it
	task automatic store(input logic m, input logic p);
		@(posedge clk_i);
		store_valid_o <= 1'b1;
		store_mini_o <= m;
		page_coalesce_o <= p;
		@(negedge clk_i);
	endtask

	// drop the store; qualifiers scrambled once invalid
	task automatic store_idle();
		@(posedge clk_i);
		store_valid_o <= 1'b0;
		store_mini_o <= ~store_mini_o;
		page_coalesce_o <= ~page_coalesce_o;
	endtask
endmodule

// File: tb/mafr_regs_tb.sv
`include "mafr_defines.svh"

module mafr_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk_i, rst_i, cyc_i, stb_i, we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, table_base_o, modified_virtual_address;
	logic        ack_o, irq_o, ab, ab_d, ab_x, ab_g, sv, sm, pc;
	logic [3:0]  ab_s, ab_m;
	logic        store_buffer_o, store_merge_o, wr_alloc, wr_thru;
	logic [1:0]  pol;
	logic [31:0] q;
	int          n_mismatch, n_checks, cycles;

	mafr_regs dut
	(
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.irq_o(irq_o), .abort_i(ab), .abort_is_data_i(ab_d), .abort_status_i(ab_s),
		.abort_ext_i(ab_x), .abort_domain_i(ab_m), .abort_debug_i(ab_g),
		.modified_virtual_address_i(modified_virtual_address), .store_valid_i(sv), .store_mini_i(sm),
		.page_coalesce_i(pc), .store_buffer_o(store_buffer_o),
		.store_merge_o(store_merge_o), .mini_cache_policy_o(pol),
		.mini_write_alloc_o(wr_alloc), .mini_write_through_o(wr_thru),
		.table_base_o(table_base_o)
	);

	mafr_core_model core
	(
		.clk_i(clk_i), .abort_o(ab), .abort_is_data_o(ab_d), .abort_status_o(ab_s),
		.abort_ext_o(ab_x), .abort_domain_o(ab_m), .abort_debug_o(ab_g),
		.address_o(modified_virtual_address), .store_valid_o(sv), .store_mini_o(sm), .page_coalesce_o(pc)
	);

	// ----------------------------------------
	// clock, hang guard, shared tasks
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// whole run is under two hundred cycles; ceiling leaves wide margin
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// classic single access; entered just after a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		dat_i <= ~d;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		for (int a = 0; a <= 8'h20; a += 4)
			rd(a[7:0], 32'h0);
		check({pol, wr_alloc, wr_thru, irq_o}, 0);
		check(table_base_o, 32'h0);
	endtask

	// every policy code, coalesce bit set, reserved bits written as ones
	task automatic t_aux();
		for (int p = 0; p < 4; p++)
		begin
			wb(1'b1, `MAFR_OFS_AUX_CTRL, 32'hffff_ffcd | (p << 4));
			rd(`MAFR_OFS_AUX_CTRL, (p << 4) | 1);
			check(pol, p);
			check({wr_alloc, wr_thru}, {p == 1, p == 2});
		end
	endtask

	// reset in mid-run must clear the policy and coalesce bits left set
	task automatic t_rerst();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`MAFR_OFS_AUX_CTRL, 32'h0);
		check(pol, 2'h0);
	endtask

	// policy settled before any store is presented
	task automatic t_store();
		for (int k = 0; k < 2; k++)
		begin
			wb(1'b1, `MAFR_OFS_AUX_CTRL, k);
			for (int i = 0; i < 4; i++)
			begin
				core.store(i[1], i[0]);
				check(store_buffer_o, i[1] | i[0]);
				check(store_merge_o, (i[1] | i[0]) & (k == 0));
			end
			core.store_idle();
		end
	endtask

	task automatic t_ttb();
		wb(1'b1, `MAFR_OFS_TTB, 32'hffff_ffff);
		rd(`MAFR_OFS_TTB, 32'hffff_c000);
		check(table_base_o, 32'hffff_c000);
		wb(1'b1, `MAFR_OFS_TTB, 32'h0001_6000);
		check(table_base_o, 32'h0001_4000);
	endtask

	task automatic t_abort();
		wb(1'b1, `MAFR_OFS_FAR, 32'h1234_5678);
		rd(`MAFR_OFS_FAR, 32'h1234_5678);
		core.abort_evt(1'b0, 4'h5, 1'b1, 4'h3, 1'b0, 32'hdead_beef);
		rd(`MAFR_OFS_FAULT, 32'h0000_0435);
		rd(`MAFR_OFS_FAR, 32'h1234_5678);
		core.abort_evt(1'b1, 4'h8, 1'b0, 4'ha, 1'b0, 32'ha5a5_0f0f);
		// one idle edge so the abort strobe is never driven twice at one edge
		@(posedge clk_i);
		core.abort_evt(1'b1, 4'hd, 1'b1, 4'h6, 1'b0, 32'h0bad_f00d);
		rd(`MAFR_OFS_FAULT, 32'h0000_046d);
		rd(`MAFR_OFS_FAR, 32'h0bad_f00d);
		core.abort_evt(1'b1, 4'h2, 1'b1, 4'hf, 1'b1, 32'h0000_1000);
		rd(`MAFR_OFS_FAULT, 32'h0000_0202);
	endtask

	// sticky events, masking, write-one-clear, unmapped place
	task automatic t_irq();
		rd(`MAFR_OFS_IRQ_STAT, 32'h7);
		check(irq_o, 1'b0);
		wb(1'b1, `MAFR_OFS_IRQ_MASK, 32'h2);
		check(irq_o, 1'b1);
		wb(1'b1, `MAFR_OFS_IRQ_STAT, 32'h2);
		check(irq_o, 1'b0);
		rd(`MAFR_OFS_IRQ_STAT, 32'h5);
		wb(1'b1, 8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 47'h0};
		n_mismatch = 0;
		n_checks = 0;
		cycles = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_aux();
		t_rerst();
		t_store();
		t_ttb();
		t_abort();
		t_irq();
		results();
	end
endmodule
